// [hdl/cpm_regfile.sv]
`timescale 1ns/1ps
`default_nettype none
module cpm_regfile
  import cpm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic supervisor_o,
  output logic trace_o,
  output logic [2:0] int_mask_o
);
  function automatic logic [31:0] bmerge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0] s);
    bmerge = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        bmerge[8*i +: 8] = n[8*i +: 8];
      end
    end
  endfunction

  function automatic logic [31:0] szmask(input cpm_size_e s);
    case (s)
      CPM_SZ_B: szmask = 32'h0000_00FF;
      CPM_SZ_W: szmask = 32'h0000_FFFF;
      default: szmask = 32'hFFFF_FFFF;
    endcase
  endfunction

  function automatic logic topbit(input logic [32:0] v,
                                  input cpm_size_e s, input logic cy);
    case (s)
      CPM_SZ_B: topbit = cy ? v[8] : v[7];
      CPM_SZ_W: topbit = cy ? v[16] : v[15];
      default: topbit = cy ? v[32] : v[31];
    endcase
  endfunction

  // Code 15 is the stack pointer of the current privilege level
  function automatic logic [4:0] slot(input logic [3:0] r,
                                      input logic s);
    slot = (r == CPM_SP_CODE && s) ? CPM_SSP_SLOT : {1'b0, r};
  endfunction

  function automatic logic [31:0] sx16(input logic [15:0] v);
    sx16 = {{16{v[15]}}, v};
  endfunction

  logic [31:0] gpr [0:CPM_NSLOT-1];
  logic [31:0] pc;
  logic [31:0] imm;
  logic [31:0] ea_ext;
  logic [31:0] ea_res;
  logic [15:0] flags;
  logic [8:0] ea_ctl;
  logic [CPM_ST_W-1:0] stat;
  logic ack;
  logic err;

  wire req = wb_cyc_i & wb_stb_i & ~ack & ~err;
  wire wr = req & wb_we_i;
  wire aligned = wb_adr_i[1:0] == 2'h0;
  wire [5:0] widx = wb_adr_i[7:2];
  wire hit_gpr = aligned & (widx <= CPM_LAST_SLOT);
  wire hit_pc = wb_adr_i == CPM_OFF_PC;
  wire hit_flags = wb_adr_i == CPM_OFF_FLAGS;
  wire hit_op = wb_adr_i == CPM_OFF_OP;
  wire hit_imm = wb_adr_i == CPM_OFF_IMM;
  wire hit_eactl = wb_adr_i == CPM_OFF_EACTL;
  wire hit_eaext = wb_adr_i == CPM_OFF_EAEXT;
  wire hit_eares = wb_adr_i == CPM_OFF_EARES;
  wire hit_stat = wb_adr_i == CPM_OFF_STAT;
  wire mapped = hit_gpr | hit_pc | hit_flags | hit_op | hit_imm |
                hit_eactl | hit_eaext | hit_eares | hit_stat;
  wire sup = flags[CPM_F_S];

  // Operation decode straight from the command word
  wire do_op = wr & hit_op;
  wire cpm_op_e opc = cpm_op_e'(wb_dat_i[4:0]);
  wire cpm_size_e sz = cpm_size_e'(wb_dat_i[CPM_OP_SZ +: 2]);
  wire [3:0] dcode = wb_dat_i[CPM_OP_DST +: 4];
  wire [3:0] scode = wb_dat_i[CPM_OP_SRC +: 4];
  wire [2:0] qraw = wb_dat_i[CPM_OP_Q +: 3];
  wire [4:0] dslot = slot(dcode, sup);
  wire [31:0] qv = (qraw == 3'h0) ? 32'h0000_0008 : {29'h0, qraw};
  wire is_q = (opc == CPM_ADDQ) | (opc == CPM_SUBQ);
  wire [31:0] b = is_q ? qv :
                  wb_dat_i[CPM_OP_IMM] ? imm : gpr[slot(scode, sup)];
  wire [31:0] a = gpr[dslot];
  wire [31:0] msk = szmask(sz);
  wire [31:0] am = a & msk;
  wire [31:0] bm = b & msk;
  wire [32:0] sum = {1'b0, am} + {1'b0, bm};
  wire [32:0] dif = {1'b0, am} - {1'b0, bm};
  wire [32:0] ngv = 33'h0 - {1'b0, am};
  wire [31:0] bx = (sz == CPM_SZ_W) ? sx16(b[15:0]) : b;
  wire [31:0] mulu = a[15:0] * b[15:0];
  wire signed [31:0] muls = $signed(a[15:0]) * $signed(b[15:0]);
  wire b0 = b[15:0] == 16'h0;
  wire [31:0] dvs = b0 ? 32'h1 : {16'h0, b[15:0]};
  wire [31:0] quq = a / dvs;
  wire [31:0] rmu = a % dvs;
  wire signed [31:0] sdv = b0 ? 32'sh1 : sx16(b[15:0]);
  wire signed [31:0] qsq = $signed(a) / sdv;
  wire signed [31:0] rms = $signed(a) % sdv;
  wire qs_ovf = qsq[31:15] != {17{qsq[15]}};
  // packed BCD add on the low byte
  wire [4:0] bl0 = {1'b0, a[3:0]} + {1'b0, b[3:0]} +
                   {4'h0, flags[CPM_F_X]};
  wire [4:0] bl = (bl0 > 5'h09) ? bl0 + 5'h06 : bl0;
  wire [4:0] bh0 = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, bl[4]};
  wire bcy = bh0 > 5'h09;
  wire [4:0] bh = bcy ? bh0 + 5'h06 : bh0;

  logic op_we;
  logic [31:0] op_val;
  logic op_fl;
  logic [4:0] nf;
  logic [31:0] rr;
  logic op_tof;
  logic [CPM_ST_W-1:0] op_set;

  always_comb begin
    op_we = 1'b0;
    op_val = 32'h0;
    op_fl = 1'b0;
    nf = flags[4:0];
    rr = 32'h0;
    op_tof = 1'b0;
    op_set = '0;
    if (dcode[3] && opc != CPM_TRAP && opc != CPM_TOFLAGS) begin
      // no byte access to address registers
      if (sz == CPM_SZ_B) begin
        op_set[CPM_ST_SIZE] = 1'b1;
      end else begin
        op_we = 1'b1;
        case (opc)
          CPM_MOVE: op_val = bx;
          CPM_ADD, CPM_ADDQ: op_val = a + bx;
          CPM_SUB, CPM_SUBQ: op_val = a - bx;
          default: begin
            op_we = 1'b0;
            op_set[CPM_ST_ILL] = 1'b1;
          end
        endcase
      end
    end else begin
      // data register at byte, word or long
      op_we = 1'b1;
      op_fl = 1'b1;
      case (opc)
        CPM_MOVE: begin
          rr = bm;
          nf[1:0] = 2'h0;
        end
        CPM_ADD, CPM_ADDQ: begin
          rr = sum[31:0];
          nf[CPM_F_C] = topbit(sum, sz, 1'b1);
          nf[CPM_F_X] = nf[CPM_F_C];
          nf[CPM_F_V] = (topbit({1'b0, am}, sz, 1'b0) ==
                         topbit({1'b0, bm}, sz, 1'b0)) &&
                        (topbit(sum, sz, 1'b0) !=
                         topbit({1'b0, am}, sz, 1'b0));
        end
        CPM_SUB, CPM_SUBQ, CPM_CMP: begin
          rr = dif[31:0];
          op_we = opc != CPM_CMP;
          nf[CPM_F_C] = topbit(dif, sz, 1'b1);
          if (opc != CPM_CMP) begin
            nf[CPM_F_X] = nf[CPM_F_C];
          end
          nf[CPM_F_V] = (topbit({1'b0, am}, sz, 1'b0) !=
                         topbit({1'b0, bm}, sz, 1'b0)) &&
                        (topbit(dif, sz, 1'b0) !=
                         topbit({1'b0, am}, sz, 1'b0));
        end
        CPM_NEG: begin
          rr = ngv[31:0];
          nf[CPM_F_C] = topbit(ngv, sz, 1'b1);
          nf[CPM_F_X] = nf[CPM_F_C];
          nf[CPM_F_V] = topbit({1'b0, am}, sz, 1'b0) &
                        topbit(ngv, sz, 1'b0);
        end
        CPM_AND, CPM_OR, CPM_EOR: begin
          rr = (opc == CPM_AND) ? am & bm :
               (opc == CPM_OR) ? am | bm : am ^ bm;
          nf[1:0] = 2'h0;
        end
        CPM_MULU, CPM_MULS: begin
          rr = (opc == CPM_MULU) ? mulu : muls;
          nf[1:0] = 2'h0;
        end
        CPM_DIVU, CPM_DIVS: begin
          nf[1:0] = 2'h0;
          if (b0) begin
            op_we = 1'b0;
            op_fl = 1'b0;
            op_set[CPM_ST_DIVZ] = 1'b1;
          end else if ((opc == CPM_DIVU) ? |quq[31:16] : qs_ovf) begin
            // Overflow keeps the dividend intact
            op_we = 1'b0;
            nf[CPM_F_V] = 1'b1;
          end else begin
            rr = (opc == CPM_DIVU) ? {rmu[15:0], quq[15:0]} :
                 {rms[15:0], qsq[15:0]};
          end
        end
        CPM_ABCD: begin
          rr = {24'h0, bh[3:0], bl[3:0]};
          nf[CPM_F_C] = bcy;
          nf[CPM_F_X] = bcy;
        end
        CPM_TRAP: begin
          op_we = 1'b0;
          op_fl = 1'b0;
          op_set[CPM_ST_TRAP] = 1'b1;
        end
        CPM_TOFLAGS: begin
          op_we = 1'b0;
          op_fl = 1'b0;
          op_tof = sup;
          op_set[CPM_ST_PRIV] = ~sup;
        end
        default: begin
          op_we = 1'b0;
          op_fl = 1'b0;
          op_set[CPM_ST_ILL] = 1'b1;
        end
      endcase
      // N and Z from the sized result, from the full 32-bit result for multiply and divide; ABCD keeps N and only clears Z
      if (opc != CPM_MULU && opc != CPM_MULS &&
          opc != CPM_DIVU && opc != CPM_DIVS) begin
        nf[CPM_F_N] = topbit({1'b0, rr}, sz, 1'b0);
        nf[CPM_F_Z] = (rr & msk) == 32'h0;
      end else begin
        nf[CPM_F_N] = rr[31];
        nf[CPM_F_Z] = rr == 32'h0;
      end
      if (opc == CPM_ABCD) begin
        nf[CPM_F_N] = flags[CPM_F_N];
        nf[CPM_F_Z] = flags[CPM_F_Z] & (rr[7:0] == 8'h0);
      end
      if (opc == CPM_MULU || opc == CPM_MULS || opc == CPM_DIVU ||
          opc == CPM_DIVS) begin
        op_val = rr;
      end else begin
        op_val = (a & ~msk) | (rr & msk);
      end
    end
    if (opc == CPM_TRAP) begin
      op_set[CPM_ST_VEC +: 4] = dcode;
    end
  end

  // Effective address unit
  wire do_ea = wr & hit_eactl;
  wire [2:0] em = wb_dat_i[2:0];
  wire [2:0] er = wb_dat_i[5:3];
  wire cpm_size_e esz = cpm_size_e'(wb_dat_i[7:6]);
  wire [4:0] aslot = slot({1'b1, er}, sup);
  wire [31:0] an = gpr[aslot];
  // index from any data or address register
  wire [31:0] xr = gpr[slot(ea_ext[15:12], sup)];
  wire [31:0] xv = ea_ext[11] ? xr : sx16(xr[15:0]);
  wire [31:0] d8x = {{24{ea_ext[7]}}, ea_ext[7:0]} + xv;
  // Byte step on the stack pointer keeps it word aligned
  wire [31:0] step = (esz == CPM_SZ_L) ? 32'h4 :
                     (esz == CPM_SZ_W || er == 3'h7) ? 32'h2 : 32'h1;

  logic [31:0] ea_val;
  logic ea_we;
  logic [31:0] ea_wv;
  logic ea_bad;

  always_comb begin
    ea_val = 32'h0;
    ea_we = 1'b0;
    ea_wv = an;
    ea_bad = 1'b0;
    case (em)
      3'h0: ea_val = gpr[{2'h0, er}];
      3'h1: ea_val = an;
      // indirect, post, pre, d16, d8 plus index
      3'h2: ea_val = an;
      3'h3: begin
        ea_val = an;
        ea_we = 1'b1;
        ea_wv = an + step;
      end
      3'h4: begin
        ea_val = an - step;
        ea_we = 1'b1;
        ea_wv = an - step;
      end
      3'h5: ea_val = an + sx16(ea_ext[15:0]);
      3'h6: ea_val = an + d8x;
      default: begin
        case (er)
          3'h0: ea_val = sx16(ea_ext[15:0]);
          3'h1: ea_val = ea_ext;
          // PC with d16 or d8 plus index
          3'h2: ea_val = pc + sx16(ea_ext[15:0]);
          3'h3: ea_val = pc + d8x;
          3'h4: ea_val = ea_ext & szmask(esz);
          default: ea_bad = 1'b1;
        endcase
      end
    endcase
  end

  // One write port, sources never collide on a single bus cycle
  wire gpr_bus = wr & hit_gpr;
  wire gpr_op = do_op & op_we;
  wire gpr_ea = do_ea & ea_we & ~ea_bad;
  wire [4:0] wslot = gpr_bus ? widx[4:0] : gpr_op ? dslot : aslot;
  wire [31:0] wval = gpr_bus ? bmerge(gpr[widx[4:0]], wb_dat_i, wb_sel_i)
                     : gpr_op ? op_val : ea_wv;
  wire gpr_we = gpr_bus | gpr_op | gpr_ea;

  // data, address, user and supervisor stack slots
  genvar g;
  for (g = 0; g < CPM_NSLOT; g++) begin : g_slot
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        gpr[g] <= 32'h0;
      end else if (gpr_we && wslot == 5'(g)) begin
        gpr[g] <= wval;
      end
    end
  end

  // user mode may only touch the condition-code byte
  wire fl_bus = wr & hit_flags;
  wire fl_priv = fl_bus & ~sup & wb_sel_i[1];
  wire [31:0] fl_m = bmerge({16'h0, flags}, wb_dat_i, wb_sel_i);
  logic [15:0] next_flags;
  always_comb begin
    next_flags = flags;
    if (fl_bus && !fl_priv) begin
      next_flags = fl_m[15:0] & CPM_FLAGS_MASK;
    end else if (do_op && op_tof) begin
      next_flags = b[15:0] & CPM_FLAGS_MASK;
    end else if (do_op && op_fl) begin
      // condition codes X N Z V C
      next_flags = {flags[15:5], nf};
    end
  end

  wire [CPM_ST_W-1:0] st_set =
    (do_op ? op_set : '0) |
    ((do_ea & ea_bad) << CPM_ST_ILL) | (fl_priv << CPM_ST_PRIV);
  wire [CPM_ST_W-1:0] st_clr =
    (wr & hit_stat) ? wb_dat_i[CPM_ST_W-1:0] : '0;
  // Set beats a simultaneous clear
  wire [CPM_ST_W-1:0] next_stat = (stat & ~st_clr) | st_set;

  wire [31:0] rdata =
    hit_gpr ? gpr[widx[4:0]] :
    hit_pc ? pc :
    hit_flags ? {16'h0, flags} :
    hit_imm ? imm :
    hit_eactl ? {23'h0, ea_ctl} :
    hit_eaext ? ea_ext :
    hit_eares ? ea_res :
    hit_stat ? {{(32 - CPM_ST_W){1'b0}}, stat} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc <= CPM_PC_RST;
      imm <= 32'h0;
      ea_ext <= 32'h0;
      ea_res <= 32'h0;
      ea_ctl <= 9'h0;
      flags <= CPM_FLAGS_RST;
      stat <= '0;
    end else begin
      if (wr & hit_pc) pc <= bmerge(pc, wb_dat_i, wb_sel_i);
      if (wr & hit_imm) imm <= bmerge(imm, wb_dat_i, wb_sel_i);
      if (wr & hit_eaext) ea_ext <= bmerge(ea_ext, wb_dat_i, wb_sel_i);
      if (do_ea) begin
        ea_ctl <= wb_dat_i[8:0];
        ea_res <= ea_val;
      end
      flags <= next_flags;
      stat <= next_stat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      err <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      ack <= req & mapped;
      err <= req & ~mapped;
      if (req & ~wb_we_i) wb_dat_o <= mapped ? rdata : 32'h0;
    end
  end

  assign wb_ack_o = ack;
  assign wb_err_o = err;
  assign supervisor_o = flags[CPM_F_S];
  assign trace_o = flags[CPM_F_T];
  // three-bit mask, levels zero to seven
  assign int_mask_o = flags[CPM_F_I +: 3];
endmodule
`default_nettype wire

// [pkg/cpm_pkg.sv]
`default_nettype none
package cpm_pkg;
  // Register map, byte addresses on an 8-bit word-aligned bus address
  localparam logic [7:0] CPM_OFF_GPR = 8'h00;
  localparam logic [7:0] CPM_OFF_PC = 8'h44;
  localparam logic [7:0] CPM_OFF_FLAGS = 8'h48;
  localparam logic [7:0] CPM_OFF_OP = 8'h4C;
  localparam logic [7:0] CPM_OFF_IMM = 8'h50;
  localparam logic [7:0] CPM_OFF_EACTL = 8'h54;
  localparam logic [7:0] CPM_OFF_EAEXT = 8'h58;
  localparam logic [7:0] CPM_OFF_EARES = 8'h5C;
  localparam logic [7:0] CPM_OFF_STAT = 8'h60;
  // Slots: 0-7 data, 8-14 address, 15 user stack, 16 supervisor stack
  localparam int CPM_NSLOT = 17;
  localparam logic [5:0] CPM_LAST_SLOT = 6'h10;
  localparam logic [3:0] CPM_SP_CODE = 4'hF;
  localparam logic [4:0] CPM_SSP_SLOT = 5'h10;
  // Flags word layout
  localparam int CPM_F_C = 0;
  localparam int CPM_F_V = 1;
  localparam int CPM_F_Z = 2;
  localparam int CPM_F_N = 3;
  localparam int CPM_F_X = 4;
  localparam int CPM_F_I = 8;
  localparam int CPM_F_S = 13;
  localparam int CPM_F_T = 15;
  localparam logic [15:0] CPM_FLAGS_MASK = 16'hA71F;
  localparam logic [15:0] CPM_FLAGS_RST = 16'h2700;
  localparam logic [31:0] CPM_PC_RST = 32'h0000_0000;
  // Operation command fields
  localparam int CPM_OP_SZ = 5;
  localparam int CPM_OP_DST = 8;
  localparam int CPM_OP_SRC = 12;
  localparam int CPM_OP_IMM = 16;
  localparam int CPM_OP_Q = 20;
  // Status bits, write one to clear
  localparam int CPM_ST_PRIV = 0;
  localparam int CPM_ST_SIZE = 1;
  localparam int CPM_ST_DIVZ = 2;
  localparam int CPM_ST_TRAP = 3;
  localparam int CPM_ST_VEC = 4;
  localparam int CPM_ST_ILL = 8;
  localparam int CPM_ST_W = 9;
  typedef enum logic [1:0] {
    CPM_SZ_B = 2'h0,
    CPM_SZ_W = 2'h1,
    CPM_SZ_L = 2'h2
  } cpm_size_e;
  typedef enum logic [4:0] {
    CPM_MOVE = 5'h00, CPM_ADD = 5'h01, CPM_SUB = 5'h02,
    CPM_CMP = 5'h03, CPM_NEG = 5'h04, CPM_AND = 5'h05,
    CPM_OR = 5'h06, CPM_EOR = 5'h07, CPM_ADDQ = 5'h08,
    CPM_SUBQ = 5'h09, CPM_MULU = 5'h0A, CPM_MULS = 5'h0B,
    CPM_DIVU = 5'h0C, CPM_DIVS = 5'h0D, CPM_ABCD = 5'h0E,
    CPM_TRAP = 5'h0F, CPM_TOFLAGS = 5'h10
  } cpm_op_e;
endpackage
`default_nettype wire

// [testbench/cpm_regfile_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module cpm_regfile_sva
  import cpm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic supervisor_o,
  input wire logic trace_o,
  input wire logic [2:0] int_mask_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req_q;
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire mapped = wb_adr_i <= CPM_OFF_STAT && wb_adr_i[1:0] == 2'h0;
  wire unmapped = !mapped;
  wire to_flags = wb_adr_i == CPM_OFF_FLAGS || wb_adr_i == CPM_OFF_OP;
  wire flag_wr = wb_ack_o && wb_we_i && to_flags;
  wire user_wr = req && wb_we_i && wb_adr_i == CPM_OFF_FLAGS;
  // Remembers a request so a stray ack can be caught
  always_ff @(posedge clk_i) begin
    req_q <= !rst_i && wb_cyc_i && wb_stb_i;
  end
  property p_map_ack;
    req && mapped |=> wb_ack_o && !wb_err_o;
  endproperty
  a_map_ack: assert property (p_map_ack)
    else $error("mapped access not acked next cycle");
  property p_unmap_err;
    req && unmapped |=> wb_err_o && !wb_ack_o;
  endproperty
  a_unmap_err: assert property (p_unmap_err)
    else $error("unmapped access not refused");
  property p_ack_cause;
    $rose(wb_ack_o) |-> req_q;
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_pulse;
    wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("answer longer than one cycle");
  property p_rst_flags;
    $fell(rst_i) |-> supervisor_o && int_mask_o == 3'h7 && !trace_o;
  endproperty
  a_rst_flags: assert property (p_rst_flags)
    else $error("flags not at reset value");
  property p_sup_cause;
    $changed(supervisor_o) |-> flag_wr;
  endproperty
  a_sup_cause: assert property (p_sup_cause)
    else $error("mode changed without write");
  property p_mask_cause;
    !flag_wr |-> $stable(int_mask_o);
  endproperty
  a_mask_cause: assert property (p_mask_cause)
    else $error("mask changed without write");
  property p_trace_cause;
    trace_o != $past(trace_o) |-> flag_wr;
  endproperty
  a_trace_cause: assert property (p_trace_cause)
    else $error("trace changed without write");
  property p_user_refuse;
    user_wr && wb_sel_i[1] && !supervisor_o |=> wb_ack_o ##0
      (!supervisor_o && $stable(int_mask_o) && $stable(trace_o));
  endproperty
  a_user_refuse: assert property (p_user_refuse)
    else $error("user write changed mode bits");
endmodule
bind cpm_regfile cpm_regfile_sva u_sva (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .wb_err_o, .supervisor_o, .trace_o, .int_mask_o);
`default_nettype wire

// [testbench/cpm_bus_host.sv]
`timescale 1ns/1ps
`default_nettype none
module cpm_bus_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic err_i,
  input wire logic [31:0] rdat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // Request held until ack or err is sampled; bounded so a hang ends
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s, output logic [31:0] q,
    output logic e, output logic to);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    sel_o <= s;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack_i === 1'b1 || err_i === 1'b1) break;
    end
    q = rdat_i;
    e = err_i;
    to = (n == 20);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cpm_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic supervisor_o, trace_o, e;
  logic [2:0] int_mask_o;
  int bad_count = 0;
  int checked = 0;
  always #25 clk_i = ~clk_i;
  cpm_regfile dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
    .supervisor_o, .trace_o, .int_mask_o);
  cpm_bus_host h (.clk_i, .ack_i(wb_ack_o), .err_i(wb_err_o),
    .rdat_i(wb_dat_o), .cyc_o(wb_cyc_i), .stb_o(wb_stb_i),
    .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s);
    logic to;
    h.xfer(w, a, d, s, q, e, to);
    if (to) begin
      bad_count++;
      $display("[FAIL] %0t bus hang", $time);
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xf(1'b1, a, d, 4'hF);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xf(1'b0, a, 32'h0, 4'hF);
    check(q, exp);
  endtask
  task automatic ea(input logic [31:0] x, input logic [31:0] c);
    wr(CPM_OFF_EAEXT, x);
    wr(CPM_OFF_EACTL, c);
  endtask
  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  initial begin
    do_reset();
    rchk(CPM_OFF_FLAGS, 32'h2700);
    check(32'(int_mask_o), 32'h7);
    for (int i = 0; i < 18; i++) wr(8'(i * 4), 32'hF0E1D2C3 + i);
    for (int i = 0; i < 18; i++) rchk(8'(i * 4), 32'hF0E1D2C3 + i);
    xf(1'b1, 8'h00, 32'h55, 4'h1);
    rchk(8'h00, 32'hF0E1D255);
    $display("registers done");
    wr(8'h00, 32'h1234FFFF);
    wr(8'h04, 32'h1);
    wr(CPM_OFF_OP, 32'h1021);
    rchk(8'h00, 32'h12340000);
    rchk(CPM_OFF_FLAGS, 32'h2715);
    wr(8'h20, 32'h10);
    wr(CPM_OFF_OP, 32'h1841);
    rchk(8'h20, 32'h11);
    rchk(CPM_OFF_FLAGS, 32'h2715);
    wr(CPM_OFF_OP, 32'h1801);
    rchk(8'h20, 32'h11);
    rchk(CPM_OFF_STAT, 32'h2);
    wr(8'h08, 32'h0);
    wr(CPM_OFF_OP, 32'h0248);
    rchk(8'h08, 32'h8);
    rchk(CPM_OFF_FLAGS, 32'h2700);
    wr(8'h0C, 32'hFFFF0003);
    wr(8'h10, 32'h00020005);
    wr(CPM_OFF_OP, 32'h432A);
    rchk(8'h0C, 32'hF);
    wr(8'h04, 32'h0);
    wr(CPM_OFF_OP, 32'h132C);
    wr(CPM_OFF_OP, 32'h050F);
    rchk(CPM_OFF_STAT, 32'h5E);
    wr(CPM_OFF_STAT, 32'h1FF);
    rchk(CPM_OFF_STAT, 32'h0);
    wr(8'h14, 32'h19);
    wr(8'h18, 32'h28);
    wr(CPM_OFF_OP, 32'h650E);
    rchk(8'h14, 32'h47);
    wr(8'h1C, 32'h7F000080);
    wr(8'h04, 32'h1);
    wr(CPM_OFF_OP, 32'h1702);
    rchk(8'h1C, 32'h7F00007F);
    rchk(CPM_OFF_FLAGS, 32'h2702);
    wr(CPM_OFF_OP, 32'h1143);
    rchk(8'h04, 32'h1);
    rchk(CPM_OFF_FLAGS, 32'h2704);
    wr(CPM_OFF_OP, 32'h0124);
    rchk(8'h04, 32'hFFFF);
    rchk(CPM_OFF_FLAGS, 32'h2719);
    wr(CPM_OFF_OP, 32'h242C);
    rchk(8'h10, 32'h00054000);
    rchk(CPM_OFF_FLAGS, 32'h2710);
    wr(CPM_OFF_OP, 32'h162B);
    rchk(8'h18, 32'hFFFFFFD8);
    rchk(CPM_OFF_FLAGS, 32'h2718);
    wr(CPM_OFF_IMM, 32'h2301);
    wr(CPM_OFF_OP, 32'h00010010);
    check(32'(int_mask_o), 32'h3);
    rchk(CPM_OFF_FLAGS, 32'h2301);
    $display("operations done");
    wr(8'h24, 32'h1000);
    wr(8'h28, 32'h100);
    ea(32'h3804, 32'h8E);
    rchk(CPM_OFF_EARES, 32'h1013);
    ea(32'hA804, 32'h8E);
    rchk(CPM_OFF_EARES, 32'h1104);
    ea(32'h0, 32'h0B);
    rchk(CPM_OFF_EARES, 32'h1000);
    rchk(8'h24, 32'h1001);
    ea(32'h0, 32'h28);
    rchk(CPM_OFF_EARES, 32'h47);
    ea(32'hFFFE, 32'h15);
    rchk(CPM_OFF_EARES, 32'hFE);
    ea(32'h8000, 32'h07);
    rchk(CPM_OFF_EARES, 32'hFFFF8000);
    ea(32'h12345678, 32'h0F);
    rchk(CPM_OFF_EARES, 32'h12345678);
    wr(CPM_OFF_PC, 32'h2000);
    ea(32'h10, 32'h17);
    rchk(CPM_OFF_EARES, 32'h2010);
    ea(32'h3000, 32'h1F);
    rchk(CPM_OFF_EARES, 32'h200F);
    ea(32'hABCD, 32'h67);
    rchk(CPM_OFF_EARES, 32'hABCD);
    ea(32'h0, 32'h3C);
    rchk(CPM_OFF_EARES, 32'hF0E1D2D1);
    rchk(8'h40, 32'hF0E1D2D1);
    ea(32'h0, 32'h2F);
    rchk(CPM_OFF_STAT, 32'h100);
    wr(CPM_OFF_STAT, 32'h1FF);
    $display("addressing done");
    xf(1'b0, 8'h64, 32'h0, 4'hF);
    check(32'(e), 32'h1);
    xf(1'b1, 8'h02, 32'h0, 4'hF);
    check(32'(e), 32'h1);
    wr(CPM_OFF_FLAGS, 32'hA700);
    check(32'(trace_o), 32'h1);
    wr(CPM_OFF_FLAGS, 32'h0);
    check(32'(supervisor_o), 32'h0);
    wr(CPM_OFF_FLAGS, 32'h2700);
    check(32'(supervisor_o), 32'h0);
    rchk(CPM_OFF_STAT, 32'h1);
    xf(1'b1, CPM_OFF_FLAGS, 32'h1F, 4'h1);
    rchk(CPM_OFF_FLAGS, 32'h1F);
    $display("modes done");
    do_reset();
    rchk(CPM_OFF_FLAGS, 32'h2700);
    check(32'(supervisor_o), 32'h1);
    $display("second reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
